// ==== pcm_pkg.sv ====
// constants and encodings of the process control mode block
// Function
// - method select: PID or on/off, default on/off
// - tuning allowed only under PID control
// - structure select: standard or heat/cool, default standard
// - small single-output part: cooling on aux two
// - large single-output part: cooling on aux four
// - self-tuning needs temp input, standard, PID; default on
// - auto-tune start accepted during self-tuning
// - program pattern off keeps program inactive
// - stop pattern: stop when soak time ends
// - continue pattern: keep running after soak
// - periods 0.1, 0.2, 0.5 or 1..99 seconds
// - period default 20 s relay, 2 s voltage
// - periods apply only for PID on relay/voltage
// - standard control: cooling period unavailable
// - current heat output: heat period unused
// - heat/cool: separate heat and cool periods
// - direct action rises with PV, reverse default
// - only alarm one accepts loop burnout type
// - type 1 alarms outside SP deviation band
// - type 2 alarms when PV above SP by X
package pcm_pkg;
	// timing
	localparam int CLOCK_PERIOD_NS = 10;
	localparam int TENTH_SECOND_NS = 100000000;
	localparam int TENTH_CYCLES = TENTH_SECOND_NS / CLOCK_PERIOD_NS;
	localparam logic [4:0] TENTHS_PER_SECOND = 5'h0a;
	// register byte addresses
	localparam logic [7:0] ADR_CONFIG = 8'h00;
	localparam logic [7:0] ADR_COMMAND = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [7:0] ADR_HEAT_PERIOD = 8'h0c;
	localparam logic [7:0] ADR_COOL_PERIOD = 8'h10;
	localparam logic [7:0] ADR_SETPOINT = 8'h14;
	localparam logic [7:0] ADR_SOAK_TIME = 8'h18;
	localparam logic [7:0] ADR_ALARM_TYPE = 8'h20;
	localparam logic [7:0] ADR_ALARM_BAND = 8'h30;
	// config field positions
	localparam int CFG_METHOD = 0;
	localparam int CFG_STRUCTURE = 1;
	localparam int CFG_SELF_TUNE = 2;
	localparam int CFG_PATTERN = 3;
	localparam int CFG_DIRECTION = 5;
	localparam int CFG_LARGE = 6;
	localparam int CFG_SINGLE = 7;
	localparam int CFG_HEAT_KIND = 8;
	localparam int CFG_COOL_KIND = 10;
	localparam int CFG_INPUT = 12;
	localparam int CFG_WIDTH = 17;
	localparam logic [16:0] CFG_RESET = 17'h05004;
	// command bits
	localparam int CMD_AT_START = 0;
	localparam int CMD_AT_CANCEL = 1;
	localparam int CMD_PROG_START = 2;
	localparam int CMD_RUN = 3;
	localparam int CMD_STOP = 4;
	// codes
	localparam logic [1:0] PAT_OFF = 2'h0;
	localparam logic [1:0] PAT_STOP = 2'h1;
	localparam logic [1:0] PAT_CONTINUE = 2'h2;
	localparam logic [1:0] KIND_RELAY = 2'h0;
	localparam logic [1:0] KIND_VOLTAGE = 2'h1;
	localparam logic [1:0] KIND_CURRENT = 2'h2;
	localparam logic [4:0] LAST_TEMP_INPUT = 5'h18;
	localparam logic [4:0] ALARM_OFF = 5'h00;
	localparam logic [4:0] ALARM_BAND_OUT = 5'h01;
	localparam logic [4:0] ALARM_UPPER = 5'h02;
	localparam logic [4:0] ALARM_LOOP_BURNOUT = 5'h0c;
	localparam logic [4:0] ALARM_LAST = 5'h11;
	// periods in tenths of a second
	localparam logic [9:0] PERIOD_RELAY = 10'h0c8;
	localparam logic [9:0] PERIOD_VOLTAGE = 10'h014;
	localparam logic [9:0] PERIOD_MAX = 10'h3de;
	localparam logic [9:0] DUTY_FULL = 10'h3e8;
	localparam logic [15:0] SETPOINT_RESET = 16'h0000;
	localparam logic [15:0] SOAK_RESET = 16'h0001;
endpackage

// ==== pcm_period_timer.sv ====
// time-proportional output timer for one control output
`timescale 1ns/1ps
module pcm_period_timer
	import pcm_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic tick, // one tenth of a second
	input wire logic [9:0] period, // period in tenths
	input wire logic [9:0] duty, // demand per mille
	output logic pulse // output on within period
);
	typedef struct packed {
		logic [9:0] count;
		logic pulse;
	} pcm_timer_t;
	pcm_timer_t state, next_state;
	logic [19:0] onTime;
	logic [19:0] elapsed;

	// compare elapsed part of the period against the demand
	always_comb begin
		next_state = state;
		onTime = {10'h000, duty} * {10'h000, period};
		elapsed = {10'h000, state.count} * {10'h000, DUTY_FULL};
		if (tick) begin
			if (state.count + 10'h001 >= period) begin
				next_state.count = 10'h000;
			end else begin
				next_state.count = state.count + 10'h001;
			end
		end
		next_state.pulse = elapsed < onTime;
	end

	// state register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign pulse = state.pulse;
endmodule // pcm_period_timer

// ==== pcm_alarm_eval.sv ====
// deviation alarm evaluation for one alarm channel
`timescale 1ns/1ps
module pcm_alarm_eval
	import pcm_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic [4:0] alarmType, // alarm type code
	input wire logic signed [15:0] pv, // process value
	input wire logic signed [15:0] setpoint, // set point
	input wire logic signed [15:0] upper, // upper deviation or X
	input wire logic signed [15:0] lower, // lower deviation
	output logic alarm // alarm state
);
	typedef struct packed {
		logic alarm;
	} pcm_alarm_t;
	pcm_alarm_t state, next_state;
	logic signed [17:0] dev;

	// deviation of PV from SP, widened against overflow
	always_comb begin
		next_state = state;
		dev = 18'(pv) - 18'(setpoint);
		case (alarmType)
			ALARM_OFF: next_state.alarm = 1'b0;
			ALARM_BAND_OUT: next_state.alarm = (dev > 18'(upper)) || (dev < -18'(lower));
			ALARM_UPPER: next_state.alarm = dev >= 18'(upper);
			default: next_state.alarm = 1'b0;
		endcase
	end

	// state register
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign alarm = state.alarm;
endmodule // pcm_alarm_eval

// ==== pcm_mode_ctrl.sv ====
// control mode, program, output period and alarm logic with wishbone registers
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
module pcm_mode_ctrl
	import pcm_pkg::*;
#(
	parameter int TENTH_COUNT = TENTH_CYCLES // cycles per tenth second
) (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	output logic [31:0] wb_dat_o, // read data
	output logic wb_ack_o, // bus acknowledge
	input wire logic signed [15:0] pv, // measured process value
	input wire logic [9:0] mvHeat, // heating demand per mille
	input wire logic [9:0] mvCool, // cooling demand per mille
	input wire logic tuneDone, // tuning finished pulse
	output logic signed [16:0] controlError, // error with action applied
	output logic heatOut, // heating control output
	output logic coolOut, // cooling control output
	output logic auxOutputTwo, // auxiliary output two
	output logic auxOutputFour, // auxiliary output four
	output logic [3:0] alarmOut, // alarm outputs
	output logic [9:0] heatLevel, // current output level
	output logic autoTuneActive, // auto-tuning running
	output logic selfTuneActive, // self-tuning running
	output logic running // run state
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [16:0] cfg;
		logic [9:0] heatPeriod;
		logic [9:0] coolPeriod;
		logic [15:0] setpoint;
		logic [15:0] soakTime;
		logic [3:0][4:0] alarmType;
		logic [3:0][31:0] alarmBand;
		logic running;
		logic autoTune;
		logic selfTune;
		logic progActive;
		logic [19:0] soakLeft;
		logic [23:0] tenthCnt;
		logic tick;
		logic heatOut;
		logic coolOut;
		logic auxTwo;
		logic auxFour;
		logic [3:0] alarmOut;
		logic [9:0] heatLevel;
		logic [16:0] ctrlErr;
	} pcm_state_t;
	pcm_state_t state, next_state;

	logic [3:0] alarmRaw;
	logic heatPulse, coolPulse;
	logic methodPid, heatCool, stEligible, heatPerOk, coolPerOk;
	logic [1:0] pattern, heatKind, coolKind;
	logic [31:0] wmask, wdata, status;
	logic [15:0] cmd;
	logic busReq;
	logic [2:0] alarmSel;
	logic [9:0] heatDuty, coolDuty;

	// byte enables into a bit mask
	function automatic logic [31:0] selMask(input logic [3:0] sel);
		selMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	// legal output period in tenths: 0.1, 0.2, 0.5 or whole seconds
	function automatic logic periodLegal(input logic [9:0] p);
		periodLegal = (p == 10'h001) || (p == 10'h002) || (p == 10'h005) ||
			((p >= 10'h00a) && (p <= PERIOD_MAX) && ((p % 10'h00a) == 10'h000));
	endfunction

	// decoded configuration
	assign methodPid = state.cfg[CFG_METHOD];
	assign heatCool = state.cfg[CFG_STRUCTURE];
	assign pattern = state.cfg[CFG_PATTERN +: 2];
	assign heatKind = state.cfg[CFG_HEAT_KIND +: 2];
	assign coolKind = state.cfg[CFG_COOL_KIND +: 2];
	assign stEligible = (state.cfg[CFG_INPUT +: 5] <= LAST_TEMP_INPUT) && !heatCool && methodPid;
	assign heatPerOk = methodPid && (heatKind == KIND_RELAY || heatKind == KIND_VOLTAGE);
	assign coolPerOk = methodPid && heatCool && (coolKind == KIND_RELAY || coolKind == KIND_VOLTAGE);

	// demand fed to the period timers, zero while stopped
	assign heatDuty = state.running ? ((mvHeat > DUTY_FULL) ? DUTY_FULL : mvHeat) : 10'h000;
	assign coolDuty = (state.running && heatCool) ? ((mvCool > DUTY_FULL) ? DUTY_FULL : mvCool) : 10'h000;

	// heating period timer
	pcm_period_timer heatTimer (
		.clock(clock),
		.rstn(rstn),
		.tick(state.tick),
		.period(state.heatPeriod),
		.duty(heatDuty),
		.pulse(heatPulse)
	);

	// cooling period timer
	pcm_period_timer coolTimer (
		.clock(clock),
		.rstn(rstn),
		.tick(state.tick),
		.period(state.coolPeriod),
		.duty(coolDuty),
		.pulse(coolPulse)
	);

	// one evaluator per alarm channel
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : gAlarm
			pcm_alarm_eval alarmUnit (
				.clock(clock),
				.rstn(rstn),
				.alarmType(state.alarmType[gi]),
				.pv(pv),
				.setpoint(state.setpoint),
				.upper(state.alarmBand[gi][15:0]),
				.lower(state.alarmBand[gi][31:16]),
				.alarm(alarmRaw[gi])
			);
		end
	endgenerate

	// status word
	always_comb begin
		status = 32'h00000000;
		status[0] = state.autoTune;
		status[1] = state.selfTune;
		status[2] = state.running;
		status[3] = state.progActive;
		status[7:4] = state.alarmOut;
		status[8] = state.heatOut;
		status[9] = state.coolOut;
		status[10] = state.auxTwo;
		status[11] = state.auxFour;
		status[12] = heatPerOk;
		status[13] = coolPerOk;
		status[14] = stEligible;
	end

	// next state: bus, commands, program, outputs
	always_comb begin
		next_state = state;
		busReq = wb_cyc_i && wb_stb_i && !state.ack;
		wmask = selMask(wb_sel_i);
		wdata = 32'h00000000;
		cmd = 16'h0000;
		alarmSel = {1'b0, wb_adr_i[3:2]};
		next_state.ack = busReq;

		// read mux, unmapped reads as zero
		if (busReq) begin
			case (wb_adr_i)
				ADR_CONFIG: next_state.rdata = {15'h0000, state.cfg};
				ADR_STATUS: next_state.rdata = status;
				ADR_HEAT_PERIOD: next_state.rdata = heatPerOk ? {22'h000000, state.heatPeriod} : 32'h00000000;
				ADR_COOL_PERIOD: next_state.rdata = coolPerOk ? {22'h000000, state.coolPeriod} : 32'h00000000;
				ADR_SETPOINT: next_state.rdata = {16'h0000, state.setpoint};
				ADR_SOAK_TIME: next_state.rdata = {16'h0000, state.soakTime};
				default: begin
					if (wb_adr_i[7:4] == ADR_ALARM_TYPE[7:4]) begin
						next_state.rdata = {27'h0000000, state.alarmType[alarmSel[1:0]]};
					end else if (wb_adr_i[7:4] == ADR_ALARM_BAND[7:4]) begin
						next_state.rdata = state.alarmBand[alarmSel[1:0]];
					end else begin
						next_state.rdata = 32'h00000000;
					end
				end
			endcase
		end

		// register writes, byte lanes merged
		if (busReq && wb_we_i) begin
			case (wb_adr_i)
				ADR_CONFIG: begin
					wdata = ({15'h0000, state.cfg} & ~wmask) | (wb_dat_i & wmask);
					next_state.cfg = wdata[CFG_WIDTH-1:0];
					// output kind change reloads its default period
					if (wdata[CFG_HEAT_KIND +: 2] != heatKind) begin
						next_state.heatPeriod = (wdata[CFG_HEAT_KIND +: 2] == KIND_VOLTAGE) ?
							PERIOD_VOLTAGE : PERIOD_RELAY;
					end
					if (wdata[CFG_COOL_KIND +: 2] != coolKind) begin
						next_state.coolPeriod = (wdata[CFG_COOL_KIND +: 2] == KIND_VOLTAGE) ?
							PERIOD_VOLTAGE : PERIOD_RELAY;
					end
				end
				ADR_COMMAND: cmd = wb_dat_i[15:0] & wmask[15:0];
				ADR_HEAT_PERIOD: begin
					wdata = ({22'h000000, state.heatPeriod} & ~wmask) | (wb_dat_i & wmask);
					if (heatPerOk && wdata[31:10] == 22'h000000 && periodLegal(wdata[9:0])) begin
						next_state.heatPeriod = wdata[9:0];
					end
				end
				ADR_COOL_PERIOD: begin
					wdata = ({22'h000000, state.coolPeriod} & ~wmask) | (wb_dat_i & wmask);
					if (coolPerOk && wdata[31:10] == 22'h000000 && periodLegal(wdata[9:0])) begin
						next_state.coolPeriod = wdata[9:0];
					end
				end
				ADR_SETPOINT: begin
					wdata = ({16'h0000, state.setpoint} & ~wmask) | (wb_dat_i & wmask);
					next_state.setpoint = wdata[15:0];
				end
				ADR_SOAK_TIME: begin
					wdata = ({16'h0000, state.soakTime} & ~wmask) | (wb_dat_i & wmask);
					next_state.soakTime = wdata[15:0];
				end
				default: begin
					if (wb_adr_i[7:4] == ADR_ALARM_TYPE[7:4] && wb_sel_i[0]) begin
						// loop burnout only on the first alarm, unknown codes refused
						if (wb_dat_i[4:0] <= ALARM_LAST &&
							(alarmSel == 3'h0 || wb_dat_i[4:0] != ALARM_LOOP_BURNOUT)) begin
							next_state.alarmType[alarmSel[1:0]] = wb_dat_i[4:0];
						end
					end else if (wb_adr_i[7:4] == ADR_ALARM_BAND[7:4]) begin
						next_state.alarmBand[alarmSel[1:0]] = (state.alarmBand[alarmSel[1:0]] & ~wmask) |
							(wb_dat_i & wmask);
					end
				end
			endcase
		end

		// tenth-second time base
		next_state.tick = 1'b0;
		if (state.tenthCnt >= 24'(TENTH_COUNT - 1)) begin
			next_state.tenthCnt = 24'h000000;
			next_state.tick = 1'b1;
		end else begin
			next_state.tenthCnt = state.tenthCnt + 24'h000001;
		end

		// run and stop commands, stop wins
		if (cmd[CMD_RUN]) begin
			next_state.running = 1'b1;
		end
		if (cmd[CMD_STOP]) begin
			next_state.running = 1'b0;
			next_state.progActive = 1'b0;
		end

		// simple program: soak countdown in tenths
		if (pattern == PAT_OFF) begin
			next_state.progActive = 1'b0;
		end else if (cmd[CMD_PROG_START] && !cmd[CMD_STOP]) begin
			next_state.progActive = 1'b1;
			next_state.running = 1'b1;
			next_state.soakLeft = 20'(state.soakTime) * 20'(TENTHS_PER_SECOND);
		end else if (state.progActive && state.tick) begin
			if (state.soakLeft <= 20'h00001) begin
				next_state.soakLeft = 20'h00000;
				next_state.progActive = 1'b0;
				if (pattern == PAT_STOP) begin
					next_state.running = 1'b0;
				end else begin
					next_state.running = state.running;
				end
			end else begin
				next_state.soakLeft = state.soakLeft - 20'h00001;
			end
		end

		// auto-tuning, start wins over clear, allowed during self-tuning
		if (!methodPid || cmd[CMD_AT_CANCEL] || tuneDone) begin
			next_state.autoTune = 1'b0;
		end
		if (cmd[CMD_AT_START] && methodPid) begin
			next_state.autoTune = 1'b1;
		end
		next_state.selfTune = state.cfg[CFG_SELF_TUNE] && stEligible && state.running;

		// error sense follows action direction
		next_state.ctrlErr = state.cfg[CFG_DIRECTION] ? (17'(pv) - 17'($signed(state.setpoint))) :
			(17'($signed(state.setpoint)) - 17'(pv));

		// control outputs
		if (!state.running) begin
			next_state.heatOut = 1'b0;
			next_state.coolOut = 1'b0;
			next_state.heatLevel = 10'h000;
		end else if (!methodPid) begin
			next_state.heatOut = $signed(state.ctrlErr) > 17'sh00000;
			next_state.coolOut = heatCool && ($signed(state.ctrlErr) < 17'sh00000);
			next_state.heatLevel = next_state.heatOut ? DUTY_FULL : 10'h000;
		end else begin
			next_state.heatOut = heatPerOk && heatPulse;
			next_state.coolOut = coolPerOk && coolPulse;
			next_state.heatLevel = (heatKind == KIND_CURRENT) ? heatDuty : 10'h000;
		end

		// alarms and auxiliary terminals, cooling takes an aux on single-output parts
		next_state.alarmOut = alarmRaw;
		next_state.auxTwo = alarmRaw[1];
		next_state.auxFour = alarmRaw[3];
		if (heatCool && state.cfg[CFG_SINGLE]) begin
			if (state.cfg[CFG_LARGE]) begin
				next_state.auxFour = next_state.coolOut;
			end else begin
				next_state.auxTwo = next_state.coolOut;
			end
		end
	end

	// state register with documented defaults
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state <= '0;
			state.cfg <= CFG_RESET;
			state.heatPeriod <= PERIOD_RELAY;
			state.coolPeriod <= PERIOD_RELAY;
			state.setpoint <= SETPOINT_RESET;
			state.soakTime <= SOAK_RESET;
			state.running <= 1'b1;
		end else begin
			state <= next_state;
		end
	end

	// outputs straight from the state register
	assign wb_dat_o = state.rdata;
	assign wb_ack_o = state.ack;
	assign controlError = state.ctrlErr;
	assign heatOut = state.heatOut;
	assign coolOut = state.coolOut;
	assign auxOutputTwo = state.auxTwo;
	assign auxOutputFour = state.auxFour;
	assign alarmOut = state.alarmOut;
	assign heatLevel = state.heatLevel;
	assign autoTuneActive = state.autoTune;
	assign selfTuneActive = state.selfTune;
	assign running = state.running;
endmodule // pcm_mode_ctrl

// ==== pcm_load_model.sv ====
// load and sensor model: registers the process value seen by the controller
`timescale 1ns/1ps
module pcm_load_model (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic signed [15:0] pvSet, // value the sensor will report
	input wire logic heatOut, // heating load drive
	input wire logic coolOut, // cooling load drive
	output logic signed [15:0] pv // measured process value
);
	// sensor sample delay of one cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pv <= 16'h0000;
		end else begin
			pv <= pvSet;
		end
	end
endmodule // pcm_load_model

// ==== pcm_mode_ctrl_properties.sv ====
// concurrent checks on the ports of the mode control block
`timescale 1ns/1ps
module pcm_mode_ctrl_props
	import pcm_pkg::*;
#(
	parameter int TENTH_COUNT = 4 // cycles per tenth second
) (
	input wire logic clock, // system clock
	input wire logic rstn, // async reset, active low
	input wire logic wb_cyc_i, // bus cycle
	input wire logic wb_stb_i, // bus strobe
	input wire logic wb_we_i, // write enable
	input wire logic [7:0] wb_adr_i, // byte address
	input wire logic [3:0] wb_sel_i, // byte enables
	input wire logic [31:0] wb_dat_i, // write data
	input wire logic [31:0] wb_dat_o, // read data
	input wire logic wb_ack_o, // bus acknowledge
	input wire logic signed [15:0] pv, // process value
	input wire logic heatOut, // heating output
	input wire logic coolOut, // cooling output
	input wire logic [3:0] alarmOut, // alarm outputs
	input wire logic selfTuneActive, // self-tuning running
	input wire logic running // run state
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// request taken, and a command write carrying one bit
	sequence takeS;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence cmdS(int b);
		takeS ##0 (wb_we_i && wb_adr_i == ADR_COMMAND && wb_sel_i[0] && wb_dat_i[b]);
	endsequence
	AST_ACK_ANSWER: assert property (takeS |=> wb_ack_o) else $error("ack missing after request");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
	AST_READ_ZERO: assert property (wb_ack_o && !$past(wb_we_i) && ($past(wb_adr_i) == ADR_COMMAND
		|| $past(wb_adr_i) >= 8'h40) |-> wb_dat_o == 32'h0) else $error("nonzero read of empty place");
	AST_STOP_CMD: assert property (cmdS(CMD_STOP) |=> !running) else $error("stop ignored");
	AST_RUN_CMD: assert property (cmdS(CMD_RUN) ##0 !wb_dat_i[CMD_STOP] |=> running)
		else $error("run ignored");
	AST_STOPPED_OUTS: assert property (!running [*3] |-> !heatOut && !coolOut)
		else $error("output on while stopped");
	AST_SELF_RUN: assert property (selfTuneActive |-> $past(running)) else $error("self-tune while stopped");
	AST_ALARM_HOLD: assert property ((!(wb_cyc_i && wb_stb_i) && $stable(pv)) [*4] |-> $stable(alarmOut))
		else $error("alarm moved with steady inputs");
endmodule // pcm_mode_ctrl_props

// ==== pcm_mode_ctrl_tb.sv ====
// self-checking testbench of the mode control block
`timescale 1ns/1ps
module pcm_mode_ctrl_tb
	import pcm_pkg::*;
;
	typedef struct {logic [1:0] ch; logic [4:0] typ; logic [15:0] up; logic [15:0] lo;
		logic [15:0] pvv; logic expAl; logic [4:0] expTyp;} pcm_row_t;
	logic clock, rstn, wbCyc, wbStb, wbWe, ack, tuneDone, heatOut, coolOut, aux2, aux4, atOn, stOn, running;
	logic [7:0] wbAdr;
	logic [3:0] wbSel, alarmOut;
	logic [31:0] wbDat, datOut, q, cfg;
	logic signed [15:0] pvSet, pv;
	logic [9:0] mvHeat, mvCool, heatLevel, prevPer;
	logic signed [16:0] ctlErr;
	int miscompares, n_tests;
	pcm_row_t rows [10] = '{
		'{2'h0, 5'h01, 16'h000a, 16'h0005, 16'h006f, 1'b1, 5'h01}, '{2'h0, 5'h01, 16'h000a, 16'h0005, 16'h006e, 1'b0, 5'h01},
		'{2'h0, 5'h01, 16'h000a, 16'h0005, 16'h005f, 1'b0, 5'h01}, '{2'h0, 5'h01, 16'h000a, 16'h0005, 16'h005e, 1'b1, 5'h01},
		'{2'h1, 5'h02, 16'h000a, 16'h0000, 16'h006e, 1'b1, 5'h02}, '{2'h1, 5'h02, 16'h000a, 16'h0000, 16'h006d, 1'b0, 5'h02},
		'{2'h2, 5'h00, 16'h0000, 16'h0000, 16'h01f4, 1'b0, 5'h00}, '{2'h3, 5'h0c, 16'h0000, 16'h0000, 16'h005e, 1'b0, 5'h00},
		'{2'h0, 5'h0c, 16'h0000, 16'h0000, 16'h005e, 1'b0, 5'h0c}, '{2'h2, 5'h12, 16'h0000, 16'h0000, 16'h005e, 1'b0, 5'h00}};
	logic [9:0] pers [8] = '{10'h001, 10'h003, 10'h002, 10'h004, 10'h005, 10'h00a, 10'h3de, 10'h3e8};
	pcm_mode_ctrl #(.TENTH_COUNT(4)) i_dut (.clock(clock), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(datOut), .wb_ack_o(ack),
		.pv(pv), .mvHeat(mvHeat), .mvCool(mvCool), .tuneDone(tuneDone), .controlError(ctlErr), .heatOut(heatOut),
		.coolOut(coolOut), .auxOutputTwo(aux2), .auxOutputFour(aux4), .alarmOut(alarmOut), .heatLevel(heatLevel),
		.autoTuneActive(atOn), .selfTuneActive(stOn), .running(running));
	pcm_load_model i_load (.clock(clock), .rstn(rstn), .pvSet(pvSet), .heatOut(heatOut), .coolOut(coolOut), .pv(pv));
	// clock of 10 ns
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// classic single cycle, held until ack is sampled
	task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		wbCyc <= 1'b1; wbStb <= 1'b1; wbWe <= we; wbAdr <= a; wbDat <= d;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = datOut;
		wbCyc <= 1'b0; wbStb <= 1'b0;
		if (n >= 50) begin
			chk(32'h1, 32'h0, "bus timeout");
			close_out();
		end
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
		end
	endtask
	task automatic setCfg(input logic [31:0] c);
		cfg = c;
		xfer(1'b1, ADR_CONFIG, c);
		repeat (4) @(posedge clock);
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (20000) @(posedge clock);
		miscompares++;
		close_out();
	end
	// main sequence
	initial begin
		rstn = 1'b0; wbCyc = 1'b0; wbStb = 1'b0; wbWe = 1'b0; wbAdr = 8'h00; wbSel = 4'hf; wbDat = 32'h0;
		pvSet = 16'h0000; mvHeat = 10'h000; mvCool = 10'h000; tuneDone = 1'b0; miscompares = 0; n_tests = 0;
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		xfer(1'b0, ADR_CONFIG, 32'h0);
		chk(q, {15'h0, CFG_RESET}, "config default");
		chk(running, 1'b1, "run after reset");
		chk(stOn, 1'b0, "self-tune on/off");
		xfer(1'b0, ADR_HEAT_PERIOD, 32'h0);
		chk(q, 32'h0, "period on/off");
		$display("test reset done");
		// alarm table
		xfer(1'b1, ADR_SETPOINT, 32'h64);
		foreach (rows[i]) begin
			xfer(1'b1, ADR_ALARM_TYPE + {4'h0, rows[i].ch, 2'h0}, {27'h0, rows[i].typ});
			xfer(1'b1, ADR_ALARM_BAND + {4'h0, rows[i].ch, 2'h0}, {rows[i].lo, rows[i].up});
			pvSet <= rows[i].pvv;
			repeat (6) @(posedge clock);
			chk(alarmOut[rows[i].ch], rows[i].expAl, "alarm state");
			xfer(1'b0, ADR_ALARM_TYPE + {4'h0, rows[i].ch, 2'h0}, 32'h0);
			chk(q, {27'h0, rows[i].expTyp}, "alarm type");
		end
		$display("test alarms done");
		// tuning
		xfer(1'b1, ADR_COMMAND, 32'h1 << CMD_AT_START);
		chk(atOn, 1'b0, "tune under on/off");
		setCfg({15'h0, CFG_RESET} | 32'h1);
		chk(stOn, 1'b1, "self-tune PID");
		xfer(1'b0, ADR_STATUS, 32'h0);
		chk(q[14:12], 3'h5, "eligible, periods");
		xfer(1'b1, ADR_COMMAND, 32'h1 << CMD_AT_START);
		chk(atOn, 1'b1, "tune during self-tune");
		tuneDone <= 1'b1;
		@(posedge clock);
		tuneDone <= 1'b0;
		repeat (2) @(posedge clock);
		chk(atOn, 1'b0, "tune done");
		xfer(1'b1, ADR_COMMAND, 32'h3);
		chk(atOn, 1'b1, "start beats cancel");
		xfer(1'b1, ADR_COMMAND, 32'h1 << CMD_AT_CANCEL);
		chk(atOn, 1'b0, "tune cancel");
		setCfg({15'h0, CFG_RESET} | 32'h1 | (32'h19 << CFG_INPUT));
		chk(stOn, 1'b0, "non-temperature input");
		$display("test tuning done");
		// periods
		xfer(1'b0, ADR_HEAT_PERIOD, 32'h0);
		chk(q, 32'(PERIOD_RELAY), "relay default");
		xfer(1'b0, ADR_COOL_PERIOD, 32'h0);
		chk(q, 32'h0, "cool unusable");
		prevPer = PERIOD_RELAY;
		foreach (pers[i]) begin
			xfer(1'b1, ADR_HEAT_PERIOD, 32'(pers[i]));
			if (pers[i] <= 10'h002 || pers[i] == 10'h005 || (pers[i] % 10 == 0 && pers[i] <= 10'h3de)) prevPer = pers[i];
			xfer(1'b0, ADR_HEAT_PERIOD, 32'h0);
			chk(q, 32'(prevPer), "period write");
		end
		setCfg(cfg | (32'(KIND_VOLTAGE) << CFG_HEAT_KIND));
		xfer(1'b0, ADR_HEAT_PERIOD, 32'h0);
		chk(q, 32'(PERIOD_VOLTAGE), "voltage default");
		mvHeat <= 10'h3ff;
		setCfg({15'h0, CFG_RESET} | 32'h1 | (32'(KIND_CURRENT) << CFG_HEAT_KIND));
		xfer(1'b0, ADR_STATUS, 32'h0);
		chk(q[12], 1'b0, "current heat");
		chk(heatLevel, DUTY_FULL, "current level clipped");
		setCfg({15'h0, CFG_RESET} | 32'h3);
		xfer(1'b0, ADR_COOL_PERIOD, 32'h0);
		chk(q, 32'(PERIOD_RELAY), "cool period");
		xfer(1'b0, ADR_STATUS, 32'h0);
		chk(q[14:12], 3'h3, "heat/cool status");
		chk({heatOut, coolOut}, 2'h2, "full heat, no cool demand");
		$display("test periods done");
		// on/off outputs, single output parts
		setCfg({15'h0, CFG_RESET} | 32'h82);
		pvSet <= 16'sd50;
		repeat (6) @(posedge clock);
		chk({heatOut, coolOut}, 2'h2, "reverse heat");
		chk(32'(ctlErr), 32'(17'sd50), "reverse error");
		pvSet <= 16'sd150;
		repeat (6) @(posedge clock);
		chk({coolOut, aux2, aux4}, 3'h6, "cool on aux two");
		setCfg(cfg | 32'h40);
		chk({coolOut, aux4}, 2'h3, "cool on aux four");
		setCfg(cfg | 32'h20);
		chk({heatOut, coolOut}, 2'h2, "direct heat");
		$display("test outputs done");
		// simple program
		xfer(1'b1, ADR_COMMAND, 32'h1 << CMD_PROG_START);
		xfer(1'b0, ADR_STATUS, 32'h0);
		chk(q[3], 1'b0, "pattern off");
		for (int p = 1; p <= 2; p++) begin
			setCfg({15'h0, CFG_RESET} | (32'(p) << CFG_PATTERN));
			xfer(1'b1, ADR_COMMAND, 32'h1 << CMD_PROG_START);
			xfer(1'b0, ADR_STATUS, 32'h0);
			chk(q[3:2], 2'h3, "program on");
			repeat (80) @(posedge clock);
			xfer(1'b0, ADR_STATUS, 32'h0);
			chk(q[3:2], (p == 1) ? 2'h0 : 2'h1, "program end");
			xfer(1'b1, ADR_COMMAND, 32'h1 << CMD_STOP);
			chk(running, 1'b0, "stop command");
			xfer(1'b1, ADR_COMMAND, 32'h1 << CMD_RUN);
		end
		$display("test program done");
		xfer(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0, "unmapped read");
		xfer(1'b0, ADR_COMMAND, 32'h0);
		chk(q, 32'h0, "command read");
		$display("test bus done");
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		xfer(1'b0, ADR_CONFIG, 32'h0);
		chk(q, {15'h0, CFG_RESET}, "config after reset");
		$display("test second reset done");
		close_out();
	end
endmodule // pcm_mode_ctrl_tb
bind pcm_mode_ctrl pcm_mode_ctrl_props #(.TENTH_COUNT(TENTH_COUNT)) i_props (.clock(clock), .rstn(rstn),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pv(pv), .heatOut(heatOut),
	.coolOut(coolOut), .alarmOut(alarmOut), .selfTuneActive(selfTuneActive), .running(running));
